/* rtl/tlb_test_pkg.sv */
// Function
// - Bits 2-0 of the linear register choose the array operation on each load.
// - Command x00 writes first-level entry at linear bits 15-12 from both registers.
// - Command x01 writes second-level entry at linear bits 17-12 and chosen set.
// - Buffer writes ignore the hit and hit-set fields of the physical register.
// - First-level read loads both registers' fields from the indexed entry.
// - First-level read sets hit flag bit 5 when the linear address hit.
// - Second-level read loads both registers, hit in bit 4, hit set in 2-0.
// - Physical register: page 31-12, cache disable 11, write-through 10, set 9-7 (0-5).
// - Linear register attribute bits; a write with valid clear invalidates the entry.
// - Lookup compares bits 31-12; hit reported only when exactly one entry matches.
// - A buffer write allocates the entry to the supplied linear page address.
// - First level is 16-entry direct mapped; second 384-entry 6-way superset of it.
//
// Purpose: Constants and entry layout for the translation buffer test port.
// Assumes: 32-bit test registers reached over a simple strobe port.
// Notes: Offsets of the two test registers on the strobe port are local choices.

package tlb_test_pkg;

  // Register port
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam logic [7:0] LINEAR_OFFSET = 8'h00;
  localparam logic [7:0] PHYSICAL_OFFSET = 8'h04;
  localparam logic [31:0] LINEAR_RESET = 32'h0000_0000;
  localparam logic [31:0] PHYSICAL_RESET = 32'h0000_0000;
  localparam logic [31:0] LINEAR_WRITE_MASK = 32'hFFFF_FF47;
  localparam logic [31:0] PHYSICAL_WRITE_MASK = 32'hFFFF_FC00;

  // Array geometry
  localparam int L1_ENTRIES = 16;
  localparam int L1_INDEX_WIDTH = 4;
  localparam int L2_SETS = 6;
  localparam int L2_ROWS = 64;
  localparam int L2_INDEX_WIDTH = 6;
  localparam int SET_WIDTH = 3;
  localparam int PAGE_WIDTH = 20;
  localparam logic [2:0] SET_MAX = 3'h5;

  // Shared field positions
  localparam int PAGE_MSB = 31;
  localparam int PAGE_LSB = 12;
  localparam int L1_IDX_MSB = 15;
  localparam int L1_IDX_LSB = 12;
  localparam int L2_IDX_MSB = 17;
  localparam int L2_IDX_LSB = 12;

  // Linear register fields
  localparam int VALID_BIT = 11;
  localparam int DIRTY_BIT = 10;
  localparam int GLOBAL_BIT = 9;
  localparam int USER_BIT = 8;
  localparam int WRITE_BIT = 6;
  localparam int CMD_MSB = 2;
  localparam int CMD_LSB = 0;

  // Physical register fields
  localparam int PCD_BIT = 11;
  localparam int PWT_BIT = 10;
  localparam int SET_MSB = 9;
  localparam int SET_LSB = 7;
  localparam int L1_HIT_BIT = 5;
  localparam int L2_HIT_BIT = 4;
  localparam int HIT_SET_INDEX_MSB = 2;
  localparam int HIT_SET_INDEX_LSB = 0;

  // Command codes; writes decode only the low two bits
  localparam logic [1:0] CMD_WRITE_L1 = 2'h0;
  localparam logic [1:0] CMD_WRITE_L2 = 2'h1;
  localparam logic [2:0] CMD_READ_L1_X = 3'h2;
  localparam logic [2:0] CMD_READ_L2_X = 3'h3;
  localparam logic [2:0] CMD_READ_L1_Y = 3'h6;
  localparam logic [2:0] CMD_READ_L2_Y = 3'h7;

  // One translation entry as held in either level
  typedef struct packed {
    logic [19:0] lin_page;
    logic valid;
    logic dirty;
    logic global_attr;
    logic user;
    logic write_protect;
    logic [19:0] phys_page;
    logic page_cache_disable;
    logic page_write_through;
  } tlb_entry_type;

endpackage

/* rtl/tlb_l2_if.sv */
// Purpose: Carries second-level array index, write and lookup signals.
// Assumes: One owner drives the request side combinationally.
// Notes: The array answers lookups in the same cycle.
`timescale 1ns/10ps

interface tlb_l2_if;
  logic [5:0] index;
  logic [2:0] set;
  logic [19:0] lookup_page;
  logic wr_en;
  tlb_test_pkg::tlb_entry_type wr_entry;
  tlb_test_pkg::tlb_entry_type rd_entry;
  logic [5:0] match;

  modport owner (output index, output set, output lookup_page, output wr_en,
                 output wr_entry, input rd_entry, input match);
  modport array (input index, input set, input lookup_page, input wr_en,
                 input wr_entry, output rd_entry, output match);
endinterface

/* rtl/tlb_l2_array.sv */
// Purpose: Second-level translation store, 64 rows by 6 sets, in flip-flops.
// Assumes: Owner never writes with a set above 5.
// Notes: All sets of a row are compared at once for hit detection.
`timescale 1ns/10ps

module tlb_l2_array (
  input wire logic sys_clk, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  tlb_l2_if.array l2        // Index, write and lookup signals
);

  tlb_test_pkg::tlb_entry_type mem_q [tlb_test_pkg::L2_SETS][tlb_test_pkg::L2_ROWS];
  tlb_test_pkg::tlb_entry_type mem_d [tlb_test_pkg::L2_SETS][tlb_test_pkg::L2_ROWS];

  // Next array contents: a single entry changes per write
  always_comb
  begin
    mem_d = mem_q;
    if (l2.wr_en && (l2.set <= tlb_test_pkg::SET_MAX))
    begin
      mem_d[l2.set][l2.index] = l2.wr_entry;
    end
  end

  // Reset clears every valid bit so no stale hit is possible
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_q <= '{default: '0};
    end
    else
    begin
      mem_q <= mem_d;
    end
  end

  // Selected set read; an out-of-range set reads as an empty entry
  assign l2.rd_entry = (l2.set <= tlb_test_pkg::SET_MAX) ? mem_q[l2.set][l2.index] : '0;

  // Per-set tag compare on the full page number
  genvar w;
  generate
    for (w = 0; w < tlb_test_pkg::L2_SETS; w++)
    begin : g_match
      assign l2.match[w] = mem_q[w][l2.index].valid &&
                           (mem_q[w][l2.index].lin_page == l2.lookup_page);
    end
  endgenerate

endmodule

/* rtl/tlb_test_port.sv */
// Purpose: Software test port into the two-level translation buffer.
// Assumes: Strobes are one cycle, never together; read data one cycle later.
// Notes: Each operation finishes at the edge that takes the linear write.
`timescale 1ns/10ps

module tlb_test_port (
  input wire logic sys_clk,          // Core clock, 100 MHz
  input wire logic reset_n,          // Asynchronous reset, active low
  input wire logic [7:0] reg_addr,   // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr,           // Write strobe
  input wire logic reg_rd,           // Read strobe
  output logic [31:0] reg_rdata,     // Read data, valid the cycle after the strobe
  output logic op_done               // Pulse after each test operation
);

  // Test registers and read path
  logic [31:0] linear_q;
  logic [31:0] linear_d;
  logic [31:0] physical_q;
  logic [31:0] physical_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic op_done_q;
  logic op_done_d;

  // First-level array
  tlb_test_pkg::tlb_entry_type l1_q [tlb_test_pkg::L1_ENTRIES];
  tlb_test_pkg::tlb_entry_type l1_d [tlb_test_pkg::L1_ENTRIES];

  // Decode helpers
  logic lin_write;
  logic phys_write;
  logic [2:0] cmd;
  logic [3:0] l1_index;
  logic [19:0] lin_page;
  logic [2:0] sel_set;
  tlb_test_pkg::tlb_entry_type new_entry;
  tlb_test_pkg::tlb_entry_type l1_entry;
  tlb_test_pkg::tlb_entry_type l2_entry;
  logic l1_hit;
  logic l2_hit;
  logic [2:0] hit_set;

  tlb_l2_if l2_bus ();

  tlb_l2_array u_l2 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .l2(l2_bus.array)
  );

  // Strobe decode and the fields of the incoming linear word
  assign lin_write = reg_wr && (reg_addr == tlb_test_pkg::LINEAR_OFFSET);
  assign phys_write = reg_wr && (reg_addr == tlb_test_pkg::PHYSICAL_OFFSET);
  assign cmd = reg_wdata[tlb_test_pkg::CMD_MSB:tlb_test_pkg::CMD_LSB];
  assign l1_index = reg_wdata[tlb_test_pkg::L1_IDX_MSB:tlb_test_pkg::L1_IDX_LSB];
  assign lin_page = reg_wdata[tlb_test_pkg::PAGE_MSB:tlb_test_pkg::PAGE_LSB];
  assign sel_set = physical_q[tlb_test_pkg::SET_MSB:tlb_test_pkg::SET_LSB];
  assign l1_entry = l1_q[l1_index];
  assign l2_entry = l2_bus.rd_entry;

  // Entry built from the linear word and the already loaded physical register;
  // the hit fields of the physical register take no part in it
  always_comb
  begin
    new_entry = '0;
    new_entry.lin_page = lin_page;
    new_entry.valid = reg_wdata[tlb_test_pkg::VALID_BIT];
    new_entry.dirty = reg_wdata[tlb_test_pkg::DIRTY_BIT];
    new_entry.global_attr = reg_wdata[tlb_test_pkg::GLOBAL_BIT];
    new_entry.user = reg_wdata[tlb_test_pkg::USER_BIT];
    new_entry.write_protect = reg_wdata[tlb_test_pkg::WRITE_BIT];
    new_entry.phys_page = physical_q[tlb_test_pkg::PAGE_MSB:tlb_test_pkg::PAGE_LSB];
    new_entry.page_cache_disable = physical_q[tlb_test_pkg::PCD_BIT];
    new_entry.page_write_through = physical_q[tlb_test_pkg::PWT_BIT];
  end

  // Second-level request: index from bits 17-12, set from the physical register
  always_comb
  begin
    l2_bus.index = reg_wdata[tlb_test_pkg::L2_IDX_MSB:tlb_test_pkg::L2_IDX_LSB];
    l2_bus.set = sel_set;
    l2_bus.lookup_page = lin_page;
    l2_bus.wr_entry = new_entry;
    l2_bus.wr_en = lin_write && (cmd[1:0] == tlb_test_pkg::CMD_WRITE_L2);
  end

  // First-level hit: direct mapped, so at most one entry can match
  assign l1_hit = l1_entry.valid && (l1_entry.lin_page == lin_page);

  // Second-level hit only for exactly one matching set, then encode it
  always_comb
  begin
    l2_hit = $onehot(l2_bus.match);
    hit_set = '0;
    for (int w = 0; w < tlb_test_pkg::L2_SETS; w++)
    begin
      if (l2_bus.match[w])
      begin
        hit_set = 3'(w);
      end
    end
  end

  // Register and first-level next state; the whole operation resolves here so
  // that a read strobe in the very next cycle already sees its results
  always_comb
  begin
    linear_d = linear_q;
    physical_d = physical_q;
    l1_d = l1_q;
    op_done_d = 1'b0;
    if (phys_write)
    begin
      // Hit fields are hardware-owned; software cannot plant a fake hit
      physical_d = (reg_wdata & tlb_test_pkg::PHYSICAL_WRITE_MASK) |
                   (physical_q & ~tlb_test_pkg::PHYSICAL_WRITE_MASK &
                    ~32'h0000_0380);
      // Set select only takes legal values 0..5
      if (reg_wdata[tlb_test_pkg::SET_MSB:tlb_test_pkg::SET_LSB] <= tlb_test_pkg::SET_MAX)
      begin
        physical_d[tlb_test_pkg::SET_MSB:tlb_test_pkg::SET_LSB] =
          reg_wdata[tlb_test_pkg::SET_MSB:tlb_test_pkg::SET_LSB];
      end
      else
      begin
        physical_d[tlb_test_pkg::SET_MSB:tlb_test_pkg::SET_LSB] = sel_set;
      end
    end
    if (lin_write)
    begin
      linear_d = reg_wdata & tlb_test_pkg::LINEAR_WRITE_MASK;
      op_done_d = 1'b1;
      if (cmd[1:0] == tlb_test_pkg::CMD_WRITE_L1)
      begin
        // Valid clear in the word invalidates the target entry
        l1_d[l1_index] = new_entry;
      end
      else if (cmd[1:0] == tlb_test_pkg::CMD_WRITE_L2)
      begin
        // Evicting a page from the second level drops its first-level copy,
        // keeping the second level a superset of the first
        if (l2_entry.valid && l1_entry.valid && (l1_entry.lin_page == l2_entry.lin_page)
            && (sel_set <= tlb_test_pkg::SET_MAX))
        begin
          l1_d[l1_index].valid = 1'b0;
        end
      end
      else if ((cmd == tlb_test_pkg::CMD_READ_L1_X) || (cmd == tlb_test_pkg::CMD_READ_L1_Y))
      begin
        // Both ports read the same array, so X and Y give the same result
        linear_d[tlb_test_pkg::PAGE_MSB:tlb_test_pkg::PAGE_LSB] = l1_entry.lin_page;
        linear_d[tlb_test_pkg::VALID_BIT] = l1_entry.valid;
        linear_d[tlb_test_pkg::DIRTY_BIT] = l1_entry.dirty;
        linear_d[tlb_test_pkg::GLOBAL_BIT] = l1_entry.global_attr;
        linear_d[tlb_test_pkg::USER_BIT] = l1_entry.user;
        linear_d[tlb_test_pkg::WRITE_BIT] = l1_entry.write_protect;
        physical_d[tlb_test_pkg::PAGE_MSB:tlb_test_pkg::PAGE_LSB] = l1_entry.phys_page;
        physical_d[tlb_test_pkg::PCD_BIT] = l1_entry.page_cache_disable;
        physical_d[tlb_test_pkg::PWT_BIT] = l1_entry.page_write_through;
        physical_d[tlb_test_pkg::L1_HIT_BIT] = l1_hit;
      end
      else
      begin
        // Codes 011 and 111: second-level read through X or Y port
        linear_d[tlb_test_pkg::PAGE_MSB:tlb_test_pkg::PAGE_LSB] = l2_entry.lin_page;
        linear_d[tlb_test_pkg::VALID_BIT] = l2_entry.valid;
        linear_d[tlb_test_pkg::DIRTY_BIT] = l2_entry.dirty;
        linear_d[tlb_test_pkg::GLOBAL_BIT] = l2_entry.global_attr;
        linear_d[tlb_test_pkg::USER_BIT] = l2_entry.user;
        linear_d[tlb_test_pkg::WRITE_BIT] = l2_entry.write_protect;
        physical_d[tlb_test_pkg::PAGE_MSB:tlb_test_pkg::PAGE_LSB] = l2_entry.phys_page;
        physical_d[tlb_test_pkg::PCD_BIT] = l2_entry.page_cache_disable;
        physical_d[tlb_test_pkg::PWT_BIT] = l2_entry.page_write_through;
        physical_d[tlb_test_pkg::L2_HIT_BIT] = l2_hit;
        if (l2_hit)
        begin
          physical_d[tlb_test_pkg::HIT_SET_INDEX_MSB:tlb_test_pkg::HIT_SET_INDEX_LSB] = hit_set;
        end
      end
    end
  end

  // Read path: data stands only in the cycle after the strobe, unmapped reads zero
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      if (reg_addr == tlb_test_pkg::LINEAR_OFFSET)
      begin
        rdata_d = linear_q;
      end
      else if (reg_addr == tlb_test_pkg::PHYSICAL_OFFSET)
      begin
        rdata_d = physical_q;
      end
    end
  end

  // State registers; only reset constants under reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      linear_q <= tlb_test_pkg::LINEAR_RESET;
      physical_q <= tlb_test_pkg::PHYSICAL_RESET;
      rdata_q <= '0;
      op_done_q <= 1'b0;
      l1_q <= '{default: '0};
    end
    else
    begin
      linear_q <= linear_d;
      physical_q <= physical_d;
      rdata_q <= rdata_d;
      op_done_q <= op_done_d;
      l1_q <= l1_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign op_done = op_done_q;

endmodule

/* verification/tlb_test_port_props.sv */
// Purpose: Port-level checks of the translation buffer test port.
// Assumes: One clock domain; bus strobes are one cycle long.
// Notes: Sees only the top module ports, attached by bind.
`timescale 1ns/10ps

module tlb_test_port_props (
  input wire logic sys_clk,          // Core clock
  input wire logic reset_n,          // Asynchronous reset, active low
  input wire logic [7:0] reg_addr,   // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr,           // Write strobe
  input wire logic reg_rd,           // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic op_done           // Operation done pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic lin_wr;
  logic lin_rd;
  logic phys_rd;
  logic phys_wr;
  logic store_wr;

  // Decoded strobes; store_wr is a linear write whose command leaves the register as written
  assign lin_wr = reg_wr && (reg_addr == tlb_test_pkg::LINEAR_OFFSET);
  assign lin_rd = reg_rd && (reg_addr == tlb_test_pkg::LINEAR_OFFSET);
  assign phys_wr = reg_wr && (reg_addr == tlb_test_pkg::PHYSICAL_OFFSET);
  assign phys_rd = reg_rd && (reg_addr == tlb_test_pkg::PHYSICAL_OFFSET);
  assign store_wr = lin_wr && !reg_wdata[1];

  done_after_write_a: assert property (lin_wr |=> op_done)
    else $error("op_done missing after linear write");
  done_only_write_a: assert property (!lin_wr |=> !op_done)
    else $error("op_done without linear write");
  rdata_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read slot");
  unmapped_read_a: assert property (reg_rd && !lin_rd && !phys_rd |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  linear_unused_a: assert property (lin_rd |=> (reg_rdata & ~tlb_test_pkg::LINEAR_WRITE_MASK) == 0)
    else $error("linear register unused bits set");
  phys_reserved_a: assert property (phys_rd |=> !reg_rdata[6] && !reg_rdata[3])
    else $error("physical register reserved bits set");
  set_range_a: assert property (phys_rd |=> reg_rdata[9:7] <= tlb_test_pkg::SET_MAX)
    else $error("set field above five");
  hit_set_range_a: assert property (phys_rd |=> reg_rdata[2:0] <= tlb_test_pkg::SET_MAX)
    else $error("hit set above five");
  linear_store_a: assert property (lin_rd && $past(store_wr) |=>
    reg_rdata == ($past(reg_wdata, 2) & tlb_test_pkg::LINEAR_WRITE_MASK))
    else $error("linear register lost written value");
  phys_store_a: assert property (phys_rd && $past(phys_wr) |=>
    (reg_rdata & 32'hFFFF_FC00) == ($past(reg_wdata, 2) & 32'hFFFF_FC00))
    else $error("physical register lost written value");

  // Main scenarios reached
  cover property (phys_rd ##1 reg_rdata[5]);
  cover property (phys_rd ##1 reg_rdata[4]);
  cover property (lin_wr ##1 lin_rd);
endmodule

bind tlb_test_port tlb_test_port_props tlb_test_port_props_inst (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_done(op_done));

/* verification/tlb_test_port_tb.sv */
// Purpose: Random and corner checks of the translation buffer test port.
// Assumes: Bench arrays mirror both buffer levels and both test registers.
// Notes: Page pool is small so hits and multi-set matches occur often.
`timescale 1ns/10ps

module tlb_test_port_tb;
  logic sys_clk, reset_n, reg_wr, reg_rd, op_done;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lin_m, phys_m, w;
  tlb_test_pkg::tlb_entry_type l1_m [16];
  tlb_test_pkg::tlb_entry_type l2_m [64][6];
  int fail_count, comparisons, cycles, seed;

  tlb_test_port tlb_test_port_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_done(op_done));

  // Core clock, 100 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard; the full run needs under 2000 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  // Physical write mirror; a set above five keeps the old set
  function automatic void model_phys(input logic [31:0] d);
    phys_m[31:10] = d[31:10];
    if (d[9:7] <= tlb_test_pkg::SET_MAX)
      phys_m[9:7] = d[9:7];
  endfunction

  // Linear write mirror plus the operation its command selects
  function automatic void model_lin(input logic [31:0] d);
    tlb_test_pkg::tlb_entry_type e;
    logic [5:0] row;
    logic [2:0] s;
    logic [2:0] hs;
    int n;
    lin_m = d & tlb_test_pkg::LINEAR_WRITE_MASK;
    row = d[17:12];
    s = phys_m[9:7];
    hs = 3'h0;
    n = 0;
    e = {d[31:12], d[11], d[10], d[9], d[8], d[6], phys_m[31:12], phys_m[11], phys_m[10]};
    if (!d[1] && !d[0])
      l1_m[d[15:12]] = e;
    else if (!d[1])
    begin
      // Replacing a valid second-level entry drops its first-level copy
      if (l2_m[row][s].valid && l1_m[d[15:12]].lin_page == l2_m[row][s].lin_page)
        l1_m[d[15:12]].valid = 1'b0;
      l2_m[row][s] = e;
    end
    else
    begin
      e = d[0] ? l2_m[row][s] : l1_m[d[15:12]];
      for (int k = 0; k < 6; k++)
        if (l2_m[row][k].valid && l2_m[row][k].lin_page == d[31:12])
        begin
          n++;
          hs = 3'(k);
        end
      if (d[0])
      begin
        phys_m[4] = (n == 1);
        if (n == 1)
          phys_m[2:0] = hs;
      end
      else
        phys_m[5] = e.valid && (e.lin_page == d[31:12]);
      lin_m[31:6] = {e.lin_page, e.valid, e.dirty, e.global_attr, e.user, 1'b0, e.write_protect};
      phys_m[31:10] = {e.phys_page, e.page_cache_disable, e.page_write_through};
    end
  endfunction

  // Write strobe stays up until the next bus task, so writes may run back to back
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    #1;
    if (a == tlb_test_pkg::PHYSICAL_OFFSET)
      model_phys(d);
    if (a == tlb_test_pkg::LINEAR_OFFSET)
    begin
      model_lin(d);
      chk1("op_done", 1'b1, op_done);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk32("read data", exp, reg_rdata);
  endtask

  initial
  begin
    seed = 53039;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    lin_m = 32'h0000_0000;
    phys_m = 32'h0000_0000;
    foreach (l1_m[i]) l1_m[i] = '0;
    foreach (l2_m[i, j]) l2_m[i][j] = '0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(tlb_test_pkg::LINEAR_OFFSET, tlb_test_pkg::LINEAR_RESET);
    rd(tlb_test_pkg::PHYSICAL_OFFSET, tlb_test_pkg::PHYSICAL_RESET);
    // Unmapped place, then a set of seven with hit fields written
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_0000);
    wr(tlb_test_pkg::PHYSICAL_OFFSET, 32'h1234_5FBF);
    rd(tlb_test_pkg::PHYSICAL_OFFSET, phys_m);
    rd(tlb_test_pkg::LINEAR_OFFSET, lin_m);
    // Random traffic over every command; linear read right after the linear write
    repeat (300)
    begin
      w = $random(seed);
      wr(tlb_test_pkg::PHYSICAL_OFFSET, w);
      w = $random(seed);
      w[31:16] = {15'h0000, w[31]};
      wr(tlb_test_pkg::LINEAR_OFFSET, w);
      rd(tlb_test_pkg::LINEAR_OFFSET, lin_m);
      rd(tlb_test_pkg::PHYSICAL_OFFSET, phys_m);
    end
    test_done();
  end
endmodule
